// ### design/rpf_pkg.sv
// package: constants and types of the radio packet framer
package rpf_pkg;
  localparam real RPF_CLK_PERIOD_NS = 10.0;
  localparam real RPF_PD2SB_XTAL_MS = 1.5;
  localparam real RPF_PD2SB_EXT_US = 150.0;
  localparam real RPF_SB2ACT_US = 130.0;
  // longest times, so rounded down to whole cycles
  localparam int RPF_PD2SB_XTAL_CYC =
    $rtoi(RPF_PD2SB_XTAL_MS * 1.0e6 / RPF_CLK_PERIOD_NS);
  localparam int RPF_PD2SB_EXT_CYC =
    $rtoi(RPF_PD2SB_EXT_US * 1.0e3 / RPF_CLK_PERIOD_NS);
  localparam int RPF_SB2ACT_CYC =
    $rtoi(RPF_SB2ACT_US * 1.0e3 / RPF_CLK_PERIOD_NS);
  localparam int RPF_TCNT_W = 18;
  localparam logic [7:0] RPF_PREAMBLE = 8'hAA;
  localparam logic [15:0] RPF_CRC_INIT = 16'hFFFF;
  localparam logic [15:0] RPF_POLY8 = 16'h0007;
  localparam logic [15:0] RPF_POLY16 = 16'h1021;
  localparam logic [6:0] RPF_FLAG_RESERVED = 7'h00;
  localparam logic [5:0] RPF_MAX_PAYLOAD = 6'h20;
  localparam logic [5:0] RPF_FLAG_LAST = 6'h01;
  localparam logic [5:0] RPF_AW_MIN = 6'h03;
  localparam logic [5:0] RPF_AW_MAX = 6'h05;

  typedef enum logic [2:0] {
    RPF_M_PDOWN, RPF_M_SETTLE, RPF_M_STBY, RPF_M_TURN,
    RPF_M_TX, RPF_M_RX, RPF_M_ACK
  } rpf_mode_e;

  typedef enum logic [2:0] {
    RPF_P_PRE, RPF_P_ADDR, RPF_P_FLAG, RPF_P_PAY,
    RPF_P_CRC, RPF_P_END, RPF_P_DLV
  } rpf_phase_e;

  typedef struct packed {
    logic power_up;
    logic ext_clock;
    logic configured;
    logic primary_rx;
    logic legacy;
    logic [2:0] addr_bytes;
    logic [1:0] crc_len;
    logic [5:0] tx_len;
    logic [5:0] rx_len;
  } rpf_cfg_s;

  typedef struct packed {
    logic [39:0] tx;
    logic [1:0][39:0] rx;
  } rpf_addr_s;

  typedef struct packed {
    logic valid;
    logic [7:0] data;
  } rpf_byte_s;

  typedef struct packed {
    rpf_mode_e mode;
    rpf_phase_e phase;
    rpf_mode_e target;
    logic [RPF_TCNT_W-1:0] tcnt;
    logic [5:0] cnt;
    logic [15:0] crc;
    logic [1:0] packet_sequence_tag;
    logic [39:0] abuf;
    logic chan;
    logic [31:0][7:0] pay;
    rpf_byte_s air;
    logic tx_ready;
    rpf_byte_s rx;
    logic sent;
    logic ready;
    logic irq_n;
  } rpf_state_s;
endpackage

// ### design/rpf_framer.sv
// module: packet framer and mode sequencer of a 2.4 GHz transceiver
`timescale 1ns/10ps

module rpf_framer #(
  parameter int PD2SB_XTAL_CYC = rpf_pkg::RPF_PD2SB_XTAL_CYC,
  parameter int PD2SB_EXT_CYC = rpf_pkg::RPF_PD2SB_EXT_CYC,
  parameter int SB2ACT_CYC = rpf_pkg::RPF_SB2ACT_CYC
) (
  input logic i_clock,
  input logic i_reset,
  input logic i_clock_enable,
  input logic i_chip_enable,
  input rpf_pkg::rpf_cfg_s i_cfg,
  input rpf_pkg::rpf_addr_s i_addr,
  input logic i_tx_resend,
  input rpf_pkg::rpf_byte_s i_tx,
  output logic o_tx_ready,
  output rpf_pkg::rpf_byte_s o_air,
  input rpf_pkg::rpf_byte_s i_air,
  output rpf_pkg::rpf_byte_s o_rx,
  output logic o_rx_channel,
  input logic i_clear_sent,
  input logic i_clear_ready,
  output logic o_data_sent_flag,
  output logic o_data_ready_flag,
  output logic o_irq_n,
  output rpf_pkg::rpf_mode_e o_mode
);
  import rpf_pkg::*;

  rpf_state_s s;
  rpf_state_s next_s;

  // bytes go in msb first; crc8 keeps its upper byte at zero
  function automatic logic [15:0] rpf_crc_next(input logic [15:0] c,
    input logic [7:0] d, input logic [1:0] len);
    logic [15:0] r;
    logic fb;
    r = c;
    for (int i = 7; i >= 0; i--)
    begin
      if (len == 2'h2)
      begin
        fb = r[15] ^ d[i];
        r = {r[14:0], 1'h0} ^ (fb ? RPF_POLY16 : 16'h0000);
      end
      else
      begin
        fb = r[7] ^ d[i];
        r = {8'h00, r[6:0], 1'h0} ^ (fb ? RPF_POLY8 : 16'h0000);
      end
    end
    return r;
  endfunction

  function automatic logic [5:0] rpf_aw(input logic [2:0] w);
    logic [5:0] v;
    v = {3'h0, w};
    if (v < RPF_AW_MIN)
      v = RPF_AW_MIN;
    else if (v > RPF_AW_MAX)
      v = RPF_AW_MAX;
    return v;
  endfunction

  // out-of-range lengths are clamped rather than hanging the framer
  function automatic logic [5:0] rpf_len(input logic [5:0] l);
    logic [5:0] v;
    v = l;
    if (v == 6'h00)
      v = 6'h01;
    else if (v > RPF_MAX_PAYLOAD)
      v = RPF_MAX_PAYLOAD;
    return v;
  endfunction

  function automatic logic rpf_match(input logic [39:0] a,
    input logic [39:0] ref_addr, input logic [5:0] w);
    logic [39:0] m;
    m = 40'hFF_FFFF_FFFF >> ({2'h0, 6'h05 - w} * 8'h08);
    return ((a ^ ref_addr) & m) == 40'h00_0000_0000;
  endfunction

  logic [7:0] b;
  logic [39:0] ab;
  logic [5:0] aw;
  logic [5:0] crc_last;
  logic [15:0] crc_b;
  logic [15:0] crc_t;
  logic [15:0] fw;
  logic [7:0] tx_byte;
  logic tx_emit;
  logic is_ack;
  logic hit0;
  logic hit1;

  always_comb
  begin
    next_s = s;
    b = i_air.data;
    aw = rpf_aw(i_cfg.addr_bytes);
    crc_last = {4'h0, i_cfg.crc_len} - 6'h01;
    ab = s.abuf;
    ab[{s.cnt[2:0], 3'h0} +: 8] = b;
    crc_b = rpf_crc_next(s.crc, b, i_cfg.crc_len);
    fw = {7'h00, s.packet_sequence_tag, RPF_FLAG_RESERVED};
    tx_byte = RPF_PREAMBLE;
    tx_emit = 1'h0;
    is_ack = (s.mode == RPF_M_ACK);
    hit0 = rpf_match(ab, i_addr.rx[0], aw);
    hit1 = rpf_match(ab, i_addr.rx[1], aw);
    next_s.air.valid = 1'h0;
    next_s.rx.valid = 1'h0;
    // a set in the same cycle overrides these clears below
    next_s.sent = s.sent & ~i_clear_sent;
    next_s.ready = s.ready & ~i_clear_ready;
    case (s.mode)
      RPF_M_PDOWN:
      begin
        if (i_cfg.power_up)
        begin
          next_s.mode = RPF_M_SETTLE;
          next_s.tcnt = i_cfg.ext_clock ? RPF_TCNT_W'(PD2SB_EXT_CYC)
            : RPF_TCNT_W'(PD2SB_XTAL_CYC);
        end
      end
      RPF_M_SETTLE:
      begin
        if (s.tcnt <= RPF_TCNT_W'(1))
          next_s.mode = RPF_M_STBY;
        else
          next_s.tcnt = s.tcnt - RPF_TCNT_W'(1);
      end
      RPF_M_STBY:
      begin
        if (i_chip_enable && i_cfg.configured)
        begin
          next_s.mode = RPF_M_TURN;
          next_s.tcnt = RPF_TCNT_W'(SB2ACT_CYC);
          next_s.target = i_cfg.primary_rx ? RPF_M_RX : RPF_M_TX;
          next_s.phase = RPF_P_PRE;
        end
      end
      RPF_M_TURN:
      begin
        if (s.tcnt <= RPF_TCNT_W'(1))
        begin
          next_s.mode = s.target;
          if (s.target == RPF_M_TX && !i_tx_resend)
            next_s.packet_sequence_tag = s.packet_sequence_tag + 2'h1;
        end
        else
          next_s.tcnt = s.tcnt - RPF_TCNT_W'(1);
      end
      RPF_M_TX:
      begin
        case (s.phase)
          RPF_P_PRE:
          begin
            tx_emit = 1'h1;
            next_s.crc = RPF_CRC_INIT;
            next_s.phase = RPF_P_ADDR;
            next_s.cnt = 6'h00;
          end
          RPF_P_ADDR:
          begin
            tx_byte = i_addr.tx[{s.cnt[2:0], 3'h0} +: 8];
            tx_emit = 1'h1;
            next_s.cnt = s.cnt + 6'h01;
            if (s.cnt == aw - 6'h01)
            begin
              next_s.cnt = 6'h00;
              next_s.phase = i_cfg.legacy ? RPF_P_PAY : RPF_P_FLAG;
              next_s.tx_ready = i_cfg.legacy;
            end
          end
          RPF_P_FLAG:
          begin
            tx_byte = s.cnt[0] ? fw[7:0] : fw[15:8];
            tx_emit = 1'h1;
            next_s.cnt = s.cnt + 6'h01;
            if (s.cnt == RPF_FLAG_LAST)
            begin
              next_s.cnt = 6'h00;
              next_s.phase = RPF_P_PAY;
              next_s.tx_ready = 1'h1;
            end
          end
          RPF_P_PAY:
          begin
            tx_byte = i_tx.data;
            if (s.tx_ready && i_tx.valid)
            begin
              tx_emit = 1'h1;
              next_s.cnt = s.cnt + 6'h01;
              if (s.cnt == rpf_len(i_cfg.tx_len) - 6'h01)
              begin
                next_s.cnt = 6'h00;
                next_s.tx_ready = 1'h0;
                next_s.phase = (i_cfg.crc_len == 2'h0) ? RPF_P_END
                  : RPF_P_CRC;
              end
            end
          end
          RPF_P_CRC:
          begin
            tx_byte = (i_cfg.crc_len == 2'h2 && s.cnt == 6'h00)
              ? s.crc[15:8] : s.crc[7:0];
            tx_emit = 1'h1;
            next_s.cnt = s.cnt + 6'h01;
            if (s.cnt == crc_last)
              next_s.phase = RPF_P_END;
          end
          default:
          begin
            // legacy peers never acknowledge, so no wait for one
            next_s.phase = RPF_P_PRE;
            next_s.cnt = 6'h00;
            if (i_cfg.legacy)
            begin
              next_s.mode = RPF_M_STBY;
              next_s.sent = 1'h1;
            end
            else
              next_s.mode = RPF_M_ACK;
          end
        endcase
      end
      RPF_M_RX, RPF_M_ACK:
      begin
        case (s.phase)
          RPF_P_PRE:
          begin
            if (!is_ack && !i_chip_enable)
              next_s.mode = RPF_M_STBY;
            else if (i_air.valid && b == RPF_PREAMBLE)
            begin
              next_s.phase = RPF_P_ADDR;
              next_s.cnt = 6'h00;
              next_s.crc = RPF_CRC_INIT;
              next_s.abuf = 40'h00_0000_0000;
            end
          end
          RPF_P_ADDR:
          begin
            if (i_air.valid)
            begin
              next_s.abuf = ab;
              next_s.crc = crc_b;
              next_s.cnt = s.cnt + 6'h01;
              if (s.cnt == aw - 6'h01)
              begin
                next_s.cnt = 6'h00;
                next_s.chan = hit1 && !hit0;
                next_s.phase = i_cfg.legacy ? RPF_P_PAY : RPF_P_FLAG;
                if (is_ack ? !rpf_match(ab, i_addr.tx, aw)
                  : !(hit0 || hit1))
                  next_s.phase = RPF_P_PRE;
              end
            end
          end
          RPF_P_FLAG:
          begin
            if (i_air.valid)
            begin
              next_s.crc = crc_b;
              next_s.cnt = s.cnt + 6'h01;
              if (s.cnt == RPF_FLAG_LAST)
              begin
                next_s.cnt = 6'h00;
                next_s.phase = !is_ack ? RPF_P_PAY
                  : (i_cfg.crc_len == 2'h0) ? RPF_P_END : RPF_P_CRC;
              end
            end
          end
          RPF_P_PAY:
          begin
            if (i_air.valid)
            begin
              next_s.pay[s.cnt[4:0]] = b;
              next_s.crc = crc_b;
              next_s.cnt = s.cnt + 6'h01;
              if (s.cnt == rpf_len(i_cfg.rx_len) - 6'h01)
              begin
                next_s.cnt = 6'h00;
                next_s.phase = (i_cfg.crc_len == 2'h0) ? RPF_P_END
                  : RPF_P_CRC;
              end
            end
          end
          RPF_P_CRC:
          begin
            // feeding the received crc through leaves a zero residue
            if (i_air.valid)
            begin
              next_s.crc = crc_b;
              next_s.cnt = s.cnt + 6'h01;
              if (s.cnt == crc_last)
              begin
                next_s.cnt = 6'h00;
                next_s.phase = (crc_b == 16'h0000) ? RPF_P_END
                  : RPF_P_PRE;
              end
            end
          end
          RPF_P_END:
          begin
            next_s.cnt = 6'h00;
            if (is_ack)
            begin
              next_s.sent = 1'h1;
              next_s.mode = RPF_M_STBY;
              next_s.phase = RPF_P_PRE;
            end
            else
              next_s.phase = RPF_P_DLV;
          end
          default:
          begin
            // air bytes arriving while delivering are not seen
            next_s.rx.valid = 1'h1;
            next_s.rx.data = s.pay[s.cnt[4:0]];
            next_s.cnt = s.cnt + 6'h01;
            if (s.cnt == rpf_len(i_cfg.rx_len) - 6'h01)
            begin
              next_s.ready = 1'h1;
              next_s.phase = RPF_P_PRE;
              next_s.cnt = 6'h00;
            end
          end
        endcase
      end
      default:
        next_s.mode = RPF_M_PDOWN;
    endcase
    crc_t = rpf_crc_next(s.crc, tx_byte, i_cfg.crc_len);
    if (tx_emit)
    begin
      next_s.air.valid = 1'h1;
      next_s.air.data = tx_byte;
      if (s.phase != RPF_P_PRE && s.phase != RPF_P_CRC)
        next_s.crc = crc_t;
    end
    if (!i_cfg.power_up)
    begin
      next_s.mode = RPF_M_PDOWN;
      next_s.phase = RPF_P_PRE;
      next_s.tx_ready = 1'h0;
    end
    next_s.irq_n = ~(next_s.sent | next_s.ready);
  end

  always_ff @(posedge i_clock or posedge i_reset)
  begin
    if (i_reset)
    begin
      s <= '0;
      s.irq_n <= 1'h1;
    end
    else if (i_clock_enable)
      s <= next_s;
  end

  assign o_tx_ready = s.tx_ready;
  assign o_air = s.air;
  assign o_rx = s.rx;
  assign o_rx_channel = s.chan;
  assign o_data_sent_flag = s.sent;
  assign o_data_ready_flag = s.ready;
  assign o_irq_n = s.irq_n;
  assign o_mode = s.mode;

  default clocking cb @(posedge i_clock);
  endclocking
  default disable iff (i_reset);

  sequence seq_pre;
    o_air.valid && o_air.data == RPF_PREAMBLE;
  endsequence
  sequence seq_addr0;
    o_air.valid && o_air.data == i_addr.tx[7:0];
  endsequence

  frame_start_a: assert property (
    (s.mode == RPF_M_TX && s.phase == RPF_P_PRE && i_clock_enable)
    ##1 i_clock_enable |-> seq_pre ##1 seq_addr0)
    else $error("frame does not open with preamble then address");

  addr_width_a: assert property (
    (s.phase == RPF_P_ADDR) |-> s.cnt < rpf_aw(i_cfg.addr_bytes))
    else $error("address byte count past configured width");

  rx_match_a: assert property (
    (s.mode == RPF_M_RX && s.phase == RPF_P_FLAG && s.cnt == 6'h00
    && $past(s.phase) == RPF_P_ADDR)
    |-> rpf_match(s.abuf, i_addr.rx[s.chan], rpf_aw(i_cfg.addr_bytes)))
    else $error("packet accepted without address match");

  tag_advance_a: assert property (
    (s.mode == RPF_M_TURN && next_s.mode == RPF_M_TX && i_clock_enable)
    |=> s.packet_sequence_tag == $past(s.packet_sequence_tag) + ($past(i_tx_resend) ? 2'h0 : 2'h1))
    else $error("packet tag not advanced correctly");

  legacy_flags_a: assert property (
    (s.mode == RPF_M_TX && i_cfg.legacy) |-> s.phase != RPF_P_FLAG)
    else $error("flag field sent in legacy format");

  crc_good_a: assert property (
    (s.phase == RPF_P_DLV && i_cfg.crc_len != 2'h0) |-> s.crc == 16'h0000)
    else $error("payload delivered with bad crc residue");

  turn_bound_a: assert property (
    (s.mode == RPF_M_TURN) |-> s.tcnt <= RPF_TCNT_W'(SB2ACT_CYC))
    else $error("turnaround count exceeds bound");

  ready_cause_a: assert property (
    $rose(o_data_ready_flag) |-> $past(s.phase) == RPF_P_DLV && !o_irq_n)
    else $error("data ready raised without delivery");

  sent_cause_a: assert property (
    $rose(o_data_sent_flag) |-> !o_irq_n && ($past(s.mode) == RPF_M_ACK
    || ($past(s.mode) == RPF_M_TX && i_cfg.legacy)))
    else $error("data sent raised without acknowledgement");

  config_gate_a: assert property (
    (s.mode == RPF_M_STBY && next_s.mode == RPF_M_TURN)
    |-> i_cfg.configured)
    else $error("active mode entered unconfigured");
endmodule // rpf_framer

// ### dv/rpf_peer.sv
// peer transceiver model at the far end of the air link
`timescale 1ns/10ps
module rpf_peer
  import rpf_pkg::*;
(
  input wire logic i_clock,
  input rpf_pkg::rpf_byte_s i_air,
  output rpf_pkg::rpf_byte_s o_air
);
  logic [7:0] got[$];
  initial o_air = '0;
  always @(posedge i_clock)
    if (i_air.valid === 1'b1)
      got.push_back(i_air.data);
  // gap cycles show inverted data so a stale byte never looks valid
  task automatic send(input logic [7:0] q[$], input int gap);
    foreach (q[k])
    begin
      o_air <= '{valid: 1'b1, data: q[k]};
      @(posedge i_clock);
      repeat (gap)
      begin
        o_air <= '{valid: 1'b0, data: ~q[k]};
        @(posedge i_clock);
      end
    end
    o_air <= '{valid: 1'b0, data: 8'h5A};
  endtask
endmodule // rpf_peer

// ### dv/radio_packet_framer_tb.sv
// self-checking bench for the radio packet framer
`timescale 1ns/10ps
module radio_packet_framer_tb;
  import rpf_pkg::*;
  localparam int XT = 20;
  localparam int EX = 10;
  localparam int SB = 8;
  logic i_clock = 1'b0;
  logic i_reset = 1'b1;
  logic ce = 1'b0;
  logic resend = 1'b0;
  logic clr_s = 1'b0;
  logic clr_r = 1'b0;
  rpf_cfg_s cfg = '0;
  rpf_addr_s adr = '0;
  rpf_byte_s tx_in = '0;
  rpf_byte_s air_o, air_i, rx_o;
  logic tx_rdy, rx_ch, sent, ready, irq_n;
  rpf_mode_e mode;
  int errors = 0;
  int tests_run = 0;
  int seed = 32'h85f53e20;
  int tx_idx = 0;
  int n;
  logic tx_go = 1'b0;
  logic [1:0] tag = 2'h0;
  logic [7:0] pay[$];
  logic [7:0] exp_q[$];
  logic [7:0] rx_q[$];

  rpf_framer #(.PD2SB_XTAL_CYC(XT), .PD2SB_EXT_CYC(EX), .SB2ACT_CYC(SB))
  rpf_framer_i (.i_clock(i_clock), .i_reset(i_reset), .i_clock_enable(1'b1),
    .i_chip_enable(ce), .i_cfg(cfg), .i_addr(adr), .i_tx_resend(resend),
    .i_tx(tx_in), .o_tx_ready(tx_rdy), .o_air(air_o), .i_air(air_i),
    .o_rx(rx_o), .o_rx_channel(rx_ch), .i_clear_sent(clr_s),
    .i_clear_ready(clr_r), .o_data_sent_flag(sent),
    .o_data_ready_flag(ready), .o_irq_n(irq_n), .o_mode(mode));
  rpf_peer rpf_peer_i (.i_clock(i_clock), .i_air(air_o), .o_air(air_i));

  always #5 i_clock = ~i_clock;
  // payload source stalls at random but holds a byte until it is taken
  always @(posedge i_clock)
  begin
    if (tx_in.valid && tx_rdy)
      tx_idx = tx_idx + 1;
    if (!(tx_in.valid && !tx_rdy))
    begin
      tx_in.valid <= tx_go && tx_idx < pay.size() && $random(seed) % 3 != 0;
      tx_in.data <= tx_idx < pay.size() ? pay[tx_idx] : 8'h00;
    end
  end
  always @(posedge i_clock)
    if (rx_o.valid === 1'b1)
      rx_q.push_back(rx_o.data);

  task automatic check(input string what, input logic [39:0] e,
    input logic [39:0] g);
    tests_run++;
    if (g !== e)
    begin
      errors++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic cmp_q(input string what, input logic [7:0] g[$]);
    check({what, " size"}, exp_q.size(), g.size());
    foreach (exp_q[k])
      if (k < g.size())
        check(what, exp_q[k], g[k]);
  endtask
  // bitwise msb-first form, equal to the bytewise register form
  function automatic logic [15:0] crc_calc(input logic [7:0] q[$], int w);
    logic [15:0] c;
    c = w == 1 ? 16'h00FF : 16'hFFFF;
    foreach (q[k])
      for (int b = 7; b >= 0; b--)
        if (w == 1)
          c = {8'h00, c[6:0], 1'b0} ^ (c[7] ^ q[k][b] ? 16'h0007 : 16'h0000);
        else
          c = {c[14:0], 1'b0} ^ (c[15] ^ q[k][b] ? 16'h1021 : 16'h0000);
    return c;
  endfunction
  task automatic build(input logic [39:0] a, int aw, logic leg, bit wp,
    int w);
    logic [15:0] c;
    exp_q = {};
    for (int k = 0; k < aw; k++)
      exp_q.push_back(a[8*k +: 8]);
    if (!leg)
    begin
      exp_q.push_back({7'h00, tag[1]});
      exp_q.push_back({tag[0], 7'h00});
    end
    if (wp)
      exp_q = {exp_q, pay};
    c = crc_calc(exp_q, w);
    if (w == 2)
      exp_q = {exp_q, c[15:8], c[7:0]};
    if (w == 1)
      exp_q.push_back(c[7:0]);
    exp_q.push_front(8'hAA);
  endtask
  task automatic gen(input int len);
    pay = {};
    repeat (len)
      pay.push_back(8'($random(seed)));
  endtask
  // random addresses make uniform or preamble-like patterns unlikely
  function automatic logic [39:0] raddr();
    return {8'($random(seed)), 32'($random(seed))};
  endfunction
  task automatic wait_mode(input rpf_mode_e m, input int lim);
    n = 0;
    while (mode !== m && n < lim)
    begin
      @(posedge i_clock);
      n++;
    end
    check("mode reached", m, mode);
  endtask
  task automatic wait_flag(input int lim);
    for (int k = 0; k < lim && sent !== 1'b1 && ready !== 1'b1; k++)
      @(posedge i_clock);
  endtask
  task automatic clear;
    clr_s <= 1'b1;
    clr_r <= 1'b1;
    @(posedge i_clock);
    clr_s <= 1'b0;
    clr_r <= 1'b0;
    repeat (2) @(posedge i_clock);
    check("irq clear", 1, irq_n);
  endtask
  // one transmit, then the peer acknowledges unless legacy
  task automatic tx_frame(input logic rs, input int len, input int w,
    input int aw, input logic leg);
    gen(len);
    tx_idx = 0;
    rpf_peer_i.got = {};
    cfg.primary_rx <= 1'b0;
    cfg.legacy <= leg;
    cfg.crc_len <= 2'(w);
    cfg.addr_bytes <= 3'(aw);
    cfg.tx_len <= 6'(len);
    resend <= rs;
    tx_go <= 1'b1;
    @(posedge i_clock);
    // chip enable held through the turnaround until TX mode is reached, no select port here to space from
    ce <= 1'b1;
    wait_mode(RPF_M_TURN, 4);
    wait_mode(RPF_M_TX, SB + 4);
    check("turn time", 1, n <= SB + 2);
    ce <= 1'b0;
    if (!rs)
      tag = tag + 2'h1;
    build(adr.tx, aw, leg, 1'b1, w);
    wait_mode(leg ? RPF_M_STBY : RPF_M_ACK, 200);
    tx_go <= 1'b0;
    cmp_q("tx frame", rpf_peer_i.got);
    if (!leg)
    begin
      build(adr.tx, aw, 1'b0, 1'b0, w);
      rpf_peer_i.send(exp_q, 1);
      wait_mode(RPF_M_STBY, 100);
    end
    check("sent flag", 1, sent);
    check("sent irq", 0, irq_n);
    clear;
  endtask
  // one frame from the peer; hit picks a matching address
  task automatic rx_frame(input int idx, input int len, input int w,
    input int aw, input logic leg, input logic hit, input logic bad);
    logic [39:0] a;
    gen(len);
    rx_q = {};
    cfg.primary_rx <= 1'b1;
    cfg.legacy <= leg;
    cfg.crc_len <= 2'(w);
    cfg.addr_bytes <= 3'(aw);
    cfg.rx_len <= 6'(len);
    ce <= 1'b1;
    @(posedge i_clock);
    wait_mode(RPF_M_RX, SB + 8);
    a = hit ? adr.rx[idx] : ~adr.rx[idx];
    build(a, aw, leg, 1'b1, w);
    if (bad)
      exp_q[exp_q.size() - 1] ^= 8'h01;
    rpf_peer_i.send(exp_q, {$random(seed)} % 3);
    wait_flag(len + 10);
    repeat (2) @(posedge i_clock);
    exp_q = {};
    if (hit && !bad)
      exp_q = pay;
    cmp_q("rx payload", rx_q);
    check("ready flag", hit && !bad, ready);
    if (hit)
      check("rx channel", idx, rx_ch);
    if (ready === 1'b1)
    begin
      check("ready irq", 0, irq_n);
      clear;
    end
  endtask
  task automatic complete_run;
    $display("comparisons %0d mismatches %0d", tests_run, errors);
    if (errors == 0 && tests_run > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  initial
  begin
    #500000;
    errors++;
    complete_run;
  end

  initial
  begin
    repeat (10) @(posedge i_clock);
    i_reset <= 1'b0;
    @(posedge i_clock);
    check("reset mode", RPF_M_PDOWN, mode);
    check("reset irq", 1, irq_n);
    adr.tx <= raddr();
    adr.rx[0] <= raddr();
    adr.rx[1] <= raddr();
    cfg.power_up <= 1'b1;
    wait_mode(RPF_M_STBY, XT + 8);
    check("xtal settle", 1, n <= XT + 2);
    cfg.power_up <= 1'b0;
    cfg.ext_clock <= 1'b1;
    wait_mode(RPF_M_PDOWN, 4);
    cfg.power_up <= 1'b1;
    wait_mode(RPF_M_STBY, EX + 8);
    check("ext settle", 1, n <= EX + 2);
    ce <= 1'b1;
    repeat (SB + 4) @(posedge i_clock);
    check("unconfigured", RPF_M_STBY, mode);
    ce <= 1'b0;
    cfg.configured <= 1'b1;
    $display("test power-up done");
    tx_frame(1'b0, 1, 2, 5, 1'b0);
    tx_frame(1'b1, 32, 1, 3, 1'b0);
    tx_frame(1'b0, 1 + {$random(seed)} % 32, 0, 4, 1'b0);
    tx_frame(1'b0, 8, 1, 3, 1'b1);
    $display("test transmit done");
    rx_frame(1, 32, 2, 5, 1'b0, 1'b1, 1'b0);
    rx_frame(0, 1, 1, 3, 1'b1, 1'b1, 1'b0);
    rx_frame(0, 1 + {$random(seed)} % 32, 0, 4, 1'b0, 1'b1, 1'b0);
    rx_frame(1, 5, 2, 4, 1'b0, 1'b1, 1'b1);
    rx_frame(0, 4, 1, 5, 1'b0, 1'b0, 1'b0);
    $display("test receive done");
    // a rejected frame may leave the hunter mid-address; reset clears it
    i_reset <= 1'b1;
    repeat (2) @(posedge i_clock);
    i_reset <= 1'b0;
    @(posedge i_clock);
    check("reset mode 2", RPF_M_PDOWN, mode);
    check("reset irq 2", 1, irq_n);
    $display("test reset done");
    complete_run;
  end
endmodule // radio_packet_framer_tb
